/* core/scd_defines.vh */
// Purpose: constants of the card command decoder
// Assumes: byte-wide command stream, 100 MHz core clock
// Notes:   included by scd_decoder.v only
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH
// ==========================================================
// header bytes
`define SCD_CLASS        8'hA0
`define SCD_HDR_LAST     3'h4
// ==========================================================
// instruction codes
`define SCD_INS_SELECT   8'hA4
`define SCD_INS_STATUS   8'hF2
`define SCD_INS_RD_BIN   8'hB0
`define SCD_INS_UP_BIN   8'hD6
`define SCD_INS_RD_REC   8'hB2
`define SCD_INS_UP_REC   8'hDC
`define SCD_INS_SEEK     8'hA2
`define SCD_INS_INCR     8'h32
`define SCD_INS_VERIFY   8'h20
`define SCD_INS_CHANGE   8'h24
`define SCD_INS_DISABLE  8'h26
`define SCD_INS_ENABLE   8'h28
`define SCD_INS_UNBLOCK  8'h2C
`define SCD_INS_INVAL    8'h04
`define SCD_INS_REHAB    8'h44
`define SCD_INS_AUTH     8'h88
`define SCD_INS_SLEEP    8'hFA
`define SCD_INS_GET_RSP  8'hC0
`define SCD_INS_PROFILE  8'h10
`define SCD_INS_ENVEL    8'hC2
`define SCD_INS_FETCH    8'h12
`define SCD_INS_TERM_RSP 8'h14
// ==========================================================
// parameter codings
`define SCD_P2_NEXT      8'h02
`define SCD_P2_PREV      8'h03
`define SCD_P2_ABS       8'h04
`define SCD_P2_CODE1     8'h01
`define SCD_P2_CODE2     8'h02
`define SCD_P2_UNBLK1    8'h00
`define SCD_LEN_INCR     8'h03
`define SCD_LEN_CODE     8'h08
`define SCD_LEN_CODE2    8'h10
`define SCD_LEN_AUTH     8'h10
`define SCD_LEN_SELECT   8'h02
`define SCD_RSP_AUTH     8'h0C
`define SCD_RSP_SEEK2    8'h01
`define SCD_RSP_ROOT     8'h16
// record mode output coding
`define SCD_RM_NEXT      2'h0
`define SCD_RM_PREV      2'h1
`define SCD_RM_ABS       2'h2
`define SCD_RM_CUR       2'h3
// ==========================================================
// status words
`define SCD_SW1_OK       8'h90
`define SCD_SW1_MORE     8'h9F
`define SCD_SW1_SEC      8'h98
`define SCD_SW2_MAXVAL   8'h50
`define SCD_SW1_TECH     8'h6F
`define SCD_SW1_LEN      8'h67
`define SCD_SW1_P1P2     8'h6B
`define SCD_SW1_INS      8'h6D
`define SCD_SW1_CLA      8'h6E
`define SCD_SW2_NONE     8'h00
`endif

/* core/scd_decoder.v */
// Purpose: command header decoder of a subscriber card
// Assumes: transport delivers bytes; file store and crypto sit behind
// Notes:   header and data bytes buffered by a small fifo before decoding
`timescale 1ns/10ps
`include "scd_defines.vh"

// ==========================================================
// fifo
module scd_fifo #(
  parameter W  = 8,
  parameter D  = 4,
  parameter AW = 2
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         arst_n_i,
  // fill side
  input  wire [W-1:0] in_data_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  // drain side
  output wire [W-1:0] out_data_o,
  output wire         out_valid_o,
  input  wire         out_ready_i
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0]   count_reg;
  // kept as not-full so the ready pin leaves a flop with no gate after it
  reg          ready_reg;
  reg          empty_reg;
  wire         push = in_valid_i & ready_reg;
  wire         pop  = out_ready_i & ~empty_reg;
  wire [AW:0]  count_next = count_reg + {{AW{1'b0}}, push}
                          - {{AW{1'b0}}, pop};
  wire [AW:0]  depth = D[AW:0];

  assign in_ready_o  = ready_reg;
  assign out_valid_o = ~empty_reg;
  assign out_data_o  = mem[rd_ptr_reg];

  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data_i;
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      ready_reg  <= 1'b1;
      empty_reg  <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == D - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == D - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      ready_reg <= (count_next != depth);
      empty_reg <= (count_next == {(AW+1){1'b0}});
    end
  end
endmodule // scd_fifo

// ==========================================================
// decoder
module scd_decoder #(
  parameter FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire       CLK_I,
  input  wire       ARST_N_I,
  // byte stream from the transport
  input  wire [7:0] RX_DATA_I,
  input  wire       RX_VALID_I,
  output wire       RX_READY_O,
  // decoded command towards the back end
  output reg        CMD_VALID_O,
  output reg  [7:0] CMD_INS_O,
  output reg  [15:0] CMD_OFFSET_O,
  output reg  [7:0] CMD_LEN_O,
  output reg  [1:0] CMD_REC_MODE_O,
  output reg  [7:0] CMD_REC_NUM_O,
  output reg  [1:0] CMD_SEEK_DIR_O,
  output reg        CMD_SEEK_TYPE2_O,
  output reg        CMD_CODE2_O,
  output reg  [7:0] CMD_PEND_INS_O,
  // command data towards the back end
  output reg  [7:0] DATA_O,
  output reg        DATA_VALID_O,
  input  wire       DATA_READY_I,
  // completion from the back end
  input  wire       DONE_I,
  input  wire [7:0] DONE_SW1_I,
  input  wire [7:0] DONE_SW2_I,
  input  wire       DONE_OVF_I,
  input  wire [7:0] RESP_LEN_I,
  // status word towards the transport
  output reg        SW_VALID_O,
  output reg  [7:0] SW1_O,
  output reg  [7:0] SW2_O
);
  localparam S_HDR  = 3'h0;
  localparam S_DEC  = 3'h1;
  localparam S_DATA = 3'h2;
  localparam S_EXEC = 3'h3;
  localparam S_STAT = 3'h4;

  // commands that carry data from the terminal
  function has_in_data;
    input [7:0] ins;
    begin
      case (ins)
        `SCD_INS_UP_BIN, `SCD_INS_UP_REC, `SCD_INS_SEEK, `SCD_INS_INCR,
        `SCD_INS_VERIFY, `SCD_INS_CHANGE, `SCD_INS_DISABLE,
        `SCD_INS_ENABLE, `SCD_INS_UNBLOCK, `SCD_INS_AUTH,
        `SCD_INS_SELECT, `SCD_INS_PROFILE, `SCD_INS_ENVEL,
        `SCD_INS_TERM_RSP:
          has_in_data = 1'b1;
        default:
          has_in_data = 1'b0;
      endcase
    end
  endfunction

  wire [7:0] f_data;
  wire       f_valid;
  wire       f_pop;

  reg  [2:0] state_reg;
  reg  [2:0] idx_reg;
  reg  [7:0] cla_reg;
  reg  [7:0] ins_reg;
  reg  [7:0] p1_reg;
  reg  [7:0] p2_reg;
  reg  [7:0] p3_reg;
  reg  [7:0] cnt_reg;
  reg        pend_ok_reg;
  reg  [7:0] pend_len_reg;
  reg  [7:0] pend_ins_reg;
  // header check result, combinational
  reg  [7:0] err_sw1;
  reg        slot_free;

  scd_fifo #(.W(8), .D(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) u_fifo (
    .clk_i       (CLK_I),
    .arst_n_i    (ARST_N_I),
    .in_data_i   (RX_DATA_I),
    .in_valid_i  (RX_VALID_I),
    .in_ready_o  (RX_READY_O),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop)
  );

  // data slot stalls the fifo, which stalls the transport
  always @*
  begin
    slot_free = ~DATA_VALID_O | DATA_READY_I;
  end
  assign f_pop = (state_reg == S_HDR) |
                 ((state_reg == S_DATA) & slot_free & (cnt_reg != 8'h00));

  always @*
  begin
    err_sw1 = 8'h00;
    if (cla_reg != `SCD_CLASS)
      err_sw1 = `SCD_SW1_CLA;
    else
      case (ins_reg)
        `SCD_INS_RD_REC, `SCD_INS_UP_REC:
          if (p2_reg != `SCD_P2_NEXT && p2_reg != `SCD_P2_PREV &&
              p2_reg != `SCD_P2_ABS)
            err_sw1 = `SCD_SW1_P1P2;
        `SCD_INS_SEEK:
          if (p2_reg[7:4] > 4'h1 || p2_reg[3:0] > 4'h3)
            err_sw1 = `SCD_SW1_P1P2;
        `SCD_INS_INCR:
          if (p3_reg != `SCD_LEN_INCR)
            err_sw1 = `SCD_SW1_LEN;
        `SCD_INS_VERIFY, `SCD_INS_CHANGE:
          if (p2_reg != `SCD_P2_CODE1 && p2_reg != `SCD_P2_CODE2)
            err_sw1 = `SCD_SW1_P1P2;
          else if (p3_reg != ((ins_reg == `SCD_INS_VERIFY) ?
                   `SCD_LEN_CODE : `SCD_LEN_CODE2))
            err_sw1 = `SCD_SW1_LEN;
        `SCD_INS_DISABLE, `SCD_INS_ENABLE:
          if (p2_reg != `SCD_P2_CODE1)
            err_sw1 = `SCD_SW1_P1P2;
          else if (p3_reg != `SCD_LEN_CODE)
            err_sw1 = `SCD_SW1_LEN;
        `SCD_INS_UNBLOCK:
          if (p2_reg != `SCD_P2_UNBLK1 && p2_reg != `SCD_P2_CODE2)
            err_sw1 = `SCD_SW1_P1P2;
          else if (p3_reg != `SCD_LEN_CODE2)
            err_sw1 = `SCD_SW1_LEN;
        `SCD_INS_AUTH:
          if (p3_reg != `SCD_LEN_AUTH)
            err_sw1 = `SCD_SW1_LEN;
        `SCD_INS_SELECT:
          if (p3_reg != `SCD_LEN_SELECT)
            err_sw1 = `SCD_SW1_LEN;
        `SCD_INS_SLEEP:
          if (p1_reg != 8'h00 || p2_reg != 8'h00)
            err_sw1 = `SCD_SW1_P1P2;
          else if (p3_reg != 8'h00)
            err_sw1 = `SCD_SW1_LEN;
        `SCD_INS_GET_RSP:
          if (!pend_ok_reg)
            err_sw1 = `SCD_SW1_TECH;
          else if (p3_reg > pend_len_reg)
            err_sw1 = `SCD_SW1_LEN;
        `SCD_INS_RD_BIN, `SCD_INS_UP_BIN, `SCD_INS_STATUS,
        `SCD_INS_INVAL, `SCD_INS_REHAB, `SCD_INS_PROFILE,
        `SCD_INS_ENVEL, `SCD_INS_FETCH, `SCD_INS_TERM_RSP:
          err_sw1 = 8'h00;
        default:
          err_sw1 = `SCD_SW1_INS;
      endcase
  end

  always @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state_reg        <= S_HDR;
      idx_reg          <= 3'h0;
      cla_reg          <= 8'h00;
      ins_reg          <= 8'h00;
      p1_reg           <= 8'h00;
      p2_reg           <= 8'h00;
      p3_reg           <= 8'h00;
      cnt_reg          <= 8'h00;
      pend_ok_reg      <= 1'b1;
      pend_len_reg     <= `SCD_RSP_ROOT;
      pend_ins_reg     <= `SCD_INS_SELECT;
      CMD_VALID_O      <= 1'b0;
      CMD_INS_O        <= 8'h00;
      CMD_OFFSET_O     <= 16'h0000;
      CMD_LEN_O        <= 8'h00;
      CMD_REC_MODE_O   <= `SCD_RM_NEXT;
      CMD_REC_NUM_O    <= 8'h00;
      CMD_SEEK_DIR_O   <= 2'h0;
      CMD_SEEK_TYPE2_O <= 1'b0;
      CMD_CODE2_O      <= 1'b0;
      CMD_PEND_INS_O   <= 8'h00;
      DATA_O           <= 8'h00;
      DATA_VALID_O     <= 1'b0;
      SW_VALID_O       <= 1'b0;
      SW1_O            <= 8'h00;
      SW2_O            <= 8'h00;
    end
    else
    begin
      CMD_VALID_O <= 1'b0;
      SW_VALID_O  <= 1'b0;
      if (DATA_READY_I)
        DATA_VALID_O <= 1'b0;
      case (state_reg)
        S_HDR:
          if (f_valid)
          begin
            case (idx_reg)
              3'h0: cla_reg <= f_data;
              3'h1: ins_reg <= f_data;
              3'h2: p1_reg  <= f_data;
              3'h3: p2_reg  <= f_data;
              default: p3_reg <= f_data;
            endcase
            if (idx_reg == `SCD_HDR_LAST)
            begin
              idx_reg   <= 3'h0;
              state_reg <= S_DEC;
            end
            else
              idx_reg <= idx_reg + 3'h1;
          end
        S_DEC:
        begin
          // any command ends the window for get response
          pend_ok_reg <= 1'b0;
          SW2_O       <= `SCD_SW2_NONE;
          if (err_sw1 != 8'h00)
          begin
            SW1_O     <= err_sw1;
            state_reg <= S_STAT;
          end
          else if (ins_reg == `SCD_INS_SLEEP)
          begin
            SW1_O     <= `SCD_SW1_OK;
            state_reg <= S_STAT;
          end
          else
          begin
            CMD_VALID_O      <= 1'b1;
            CMD_INS_O        <= ins_reg;
            CMD_OFFSET_O     <= {p1_reg, p2_reg};
            CMD_LEN_O        <= p3_reg;
            CMD_SEEK_DIR_O   <= p2_reg[1:0];
            CMD_SEEK_TYPE2_O <= p2_reg[4];
            CMD_CODE2_O      <= (p2_reg == `SCD_P2_CODE2);
            CMD_PEND_INS_O   <= pend_ins_reg;
            if (p2_reg == `SCD_P2_NEXT)
            begin
              CMD_REC_MODE_O <= `SCD_RM_NEXT;
              CMD_REC_NUM_O  <= 8'h00;
            end
            else if (p2_reg == `SCD_P2_PREV)
            begin
              CMD_REC_MODE_O <= `SCD_RM_PREV;
              CMD_REC_NUM_O  <= 8'h00;
            end
            else
            begin
              CMD_REC_MODE_O <= (p1_reg == 8'h00) ? `SCD_RM_CUR
                                                  : `SCD_RM_ABS;
              CMD_REC_NUM_O  <= p1_reg;
            end
            cnt_reg   <= has_in_data(ins_reg) ? p3_reg : 8'h00;
            state_reg <= has_in_data(ins_reg) ? S_DATA : S_EXEC;
          end
        end
        S_DATA:
          if (slot_free)
          begin
            if (cnt_reg == 8'h00)
              state_reg <= S_EXEC;
            else if (f_valid)
            begin
              DATA_O       <= f_data;
              DATA_VALID_O <= 1'b1;
              cnt_reg      <= cnt_reg - 8'h01;
            end
          end
        S_EXEC:
          if (DONE_I)
          begin
            state_reg <= S_STAT;
            if (DONE_OVF_I && ins_reg == `SCD_INS_INCR)
            begin
              SW1_O <= `SCD_SW1_SEC;
              SW2_O <= `SCD_SW2_MAXVAL;
            end
            else if (DONE_SW1_I == `SCD_SW1_OK &&
                     (ins_reg == `SCD_INS_AUTH ||
                      (ins_reg == `SCD_INS_SEEK && p2_reg[4]) ||
                      ins_reg == `SCD_INS_SELECT ||
                      ins_reg == `SCD_INS_INCR ||
                      ins_reg == `SCD_INS_ENVEL))
            begin
              SW1_O        <= `SCD_SW1_MORE;
              pend_ok_reg  <= 1'b1;
              pend_ins_reg <= ins_reg;
              if (ins_reg == `SCD_INS_AUTH)
              begin
                SW2_O        <= `SCD_RSP_AUTH;
                pend_len_reg <= `SCD_RSP_AUTH;
              end
              else if (ins_reg == `SCD_INS_SEEK)
              begin
                SW2_O        <= `SCD_RSP_SEEK2;
                pend_len_reg <= `SCD_RSP_SEEK2;
              end
              else
              begin
                SW2_O        <= RESP_LEN_I;
                pend_len_reg <= RESP_LEN_I;
              end
            end
            else
            begin
              SW1_O <= DONE_SW1_I;
              SW2_O <= DONE_SW2_I;
            end
          end
        S_STAT:
        begin
          SW_VALID_O <= 1'b1;
          state_reg  <= S_HDR;
        end
        default:
          state_reg <= S_HDR;
      endcase
    end
  end
endmodule // scd_decoder

/* dv/scd_monitor.sv */
// Purpose: port checker of the card command decoder
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to scd_decoder at the foot of this file
`timescale 1ns/10ps
module scd_monitor #(
  parameter FIFO_DEPTH = 4
) (
  // clock and reset
  input wire        CLK_I,
  input wire        ARST_N_I,
  // decoded command
  input wire        CMD_VALID_O,
  input wire [7:0]  CMD_INS_O,
  input wire [15:0] CMD_OFFSET_O,
  input wire [1:0]  CMD_REC_MODE_O,
  input wire [7:0]  CMD_REC_NUM_O,
  input wire [1:0]  CMD_SEEK_DIR_O,
  input wire        CMD_SEEK_TYPE2_O,
  input wire        CMD_CODE2_O,
  // completion and status
  input wire        DONE_I,
  input wire [7:0]  DONE_SW1_I,
  input wire        DONE_OVF_I,
  input wire        SW_VALID_O,
  input wire [7:0]  SW1_O,
  input wire [7:0]  SW2_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  wire rec = CMD_INS_O == 8'hB2 || CMD_INS_O == 8'hDC;
  // ==========================================================
  // properties
  property p_cmd_pulse;
    CMD_VALID_O |=> !CMD_VALID_O;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command strobe longer than one cycle");
  property p_rec_ign;
    CMD_VALID_O && rec && CMD_REC_MODE_O < 2'h2 |->
      CMD_REC_NUM_O == 8'h00 && CMD_REC_MODE_O[0] == CMD_OFFSET_O[0];
  endproperty
  a_rec_ign: assert property (p_rec_ign)
    else $error("record number passed in relative mode");
  property p_rec_abs;
    CMD_VALID_O && rec && CMD_OFFSET_O[7:0] == 8'h04 |->
      CMD_REC_NUM_O == CMD_OFFSET_O[15:8] &&
      CMD_REC_MODE_O == (CMD_OFFSET_O[15:8] == 8'h00 ? 2'h3 : 2'h2);
  endproperty
  a_rec_abs: assert property (p_rec_abs)
    else $error("absolute record mode wrong");
  property p_seek;
    CMD_VALID_O && CMD_INS_O == 8'hA2 |->
      CMD_SEEK_DIR_O == CMD_OFFSET_O[1:0] &&
      CMD_SEEK_TYPE2_O == CMD_OFFSET_O[4];
  endproperty
  a_seek: assert property (p_seek)
    else $error("search fields wrong");
  property p_unblock;
    CMD_VALID_O && CMD_INS_O == 8'h2C |->
      (CMD_OFFSET_O[7:0] & 8'hFD) == 8'h00 &&
      CMD_CODE2_O == CMD_OFFSET_O[1];
  endproperty
  a_unblock: assert property (p_unblock)
    else $error("unblock code select wrong");
  property p_more;
    SW_VALID_O && SW1_O == 8'h9F |->
      (CMD_INS_O == 8'h88 && SW2_O == 8'h0C) ||
      (CMD_INS_O == 8'hA2 && CMD_SEEK_TYPE2_O && SW2_O == 8'h01) ||
      CMD_INS_O inside {8'hA4, 8'h32, 8'hC2};
  endproperty
  a_more: assert property (p_more)
    else $error("pending data status after wrong command");
  property p_seek1;
    SW_VALID_O && CMD_INS_O == 8'hA2 && !CMD_SEEK_TYPE2_O |->
      SW1_O != 8'h9F;
  endproperty
  a_seek1: assert property (p_seek1)
    else $error("type 1 search offered data");
  property p_ovf;
    DONE_I && DONE_OVF_I && CMD_INS_O == 8'h32 |->
      ##[1:3] SW_VALID_O && SW1_O == 8'h98 && SW2_O == 8'h50;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow status missing");
  property p_ok;
    DONE_I && !DONE_OVF_I && DONE_SW1_I == 8'h90 &&
      (CMD_INS_O == 8'hD6 || rec) |->
      ##[1:3] SW_VALID_O && SW1_O == 8'h90 && SW2_O == 8'h00;
  endproperty
  a_ok: assert property (p_ok)
    else $error("normal ending status missing");
  c_more: cover property (SW_VALID_O && SW1_O == 8'h9F);
  c_unblock: cover property (CMD_VALID_O && CMD_INS_O == 8'h2C);
  c_ovf: cover property (DONE_I && DONE_OVF_I);
endmodule // scd_monitor

bind scd_decoder scd_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .CMD_VALID_O(CMD_VALID_O),
  .CMD_INS_O(CMD_INS_O), .CMD_OFFSET_O(CMD_OFFSET_O),
  .CMD_REC_MODE_O(CMD_REC_MODE_O), .CMD_REC_NUM_O(CMD_REC_NUM_O),
  .CMD_SEEK_DIR_O(CMD_SEEK_DIR_O), .CMD_SEEK_TYPE2_O(CMD_SEEK_TYPE2_O),
  .CMD_CODE2_O(CMD_CODE2_O), .DONE_I(DONE_I), .DONE_SW1_I(DONE_SW1_I),
  .DONE_OVF_I(DONE_OVF_I), .SW_VALID_O(SW_VALID_O), .SW1_O(SW1_O),
  .SW2_O(SW2_O));

/* dv/scd_backend_model.sv */
// Purpose: behavioural back end behind the decoder
// Assumes: every command ends with status 90 00
// Notes:   slow_i halves the data acceptance rate
`timescale 1ns/10ps
module scd_backend_model (
  // clock and reset
  input  wire       clk_i,
  input  wire       arst_n_i,
  // command side
  input  wire       cmd_valid_i,
  input  wire [7:0] cmd_ins_i,
  input  wire [7:0] cmd_len_i,
  input  wire [7:0] data_i,
  input  wire       data_valid_i,
  output wire       data_ready_o,
  input  wire       slow_i,
  // completion side
  output reg        done_o,
  output wire [7:0] sw1_o,
  output reg  [7:0] got_o,
  output reg  [7:0] last_o
);
  reg       busy_reg;
  reg       tog_reg;
  reg [7:0] need_reg;
  reg [1:0] dly_reg;
  assign data_ready_o = busy_reg & (~slow_i | tog_reg);
  assign sw1_o = 8'h90;
  function has_data(input [7:0] ins);
    case (ins)
      8'hD6, 8'hDC, 8'hA2, 8'h32, 8'h20, 8'h24, 8'h26, 8'h28, 8'h2C,
      8'h88, 8'hA4, 8'h10, 8'hC2, 8'h14: has_data = 1'b1;
      default: has_data = 1'b0;
    endcase
  endfunction
  // done only after the whole payload, never early
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      {busy_reg, tog_reg, need_reg, dly_reg, done_o} <= 13'h0000;
      got_o <= 8'h00;
      last_o <= 8'h00;
    end
    else
    begin
      tog_reg <= ~tog_reg;
      done_o <= 1'b0;
      if (cmd_valid_i)
      begin
        busy_reg <= 1'b1;
        got_o <= 8'h00;
        dly_reg <= 2'h0;
        need_reg <= has_data(cmd_ins_i) ? cmd_len_i : 8'h00;
      end
      else if (busy_reg && data_valid_i && data_ready_o)
      begin
        got_o <= got_o + 8'h01;
        last_o <= data_i;
      end
      else if (busy_reg && got_o == need_reg)
      begin
        dly_reg <= dly_reg + 2'h1;
        if (dly_reg == 2'h3)
        begin
          done_o <= 1'b1;
          busy_reg <= 1'b0;
        end
      end
    end
  end
endmodule // scd_backend_model

/* dv/testbench.sv */
// Purpose: self-checking bench of the card command decoder
// Assumes: bytes offered one per cycle by the terminal side
// Notes:   waits sample at the falling edge
`timescale 1ns/10ps
module testbench;
  reg        clk = 1'b0;
  reg        arst_n = 1'b0;
  reg  [7:0] rx_data = 8'h00;
  reg        rx_valid = 1'b0;
  reg        ovf = 1'b0;
  reg        slow = 1'b0;
  reg  [7:0] rlen = 8'h00;
  reg        saw_full = 1'b0;
  reg [15:0] sw_word;
  integer    errors = 0;
  integer    checked = 0;
  integer    ncmd = 0;
  wire       rdy, cv, st2, c2, dv, drdy, done, swv;
  wire [7:0] ins, len, rnum, pend, dat, dsw1, s1, s2, got, last;
  wire [15:0] off;
  wire [1:0] rmode, sdir;
  always #5 clk = ~clk;
  scd_decoder #(.FIFO_DEPTH(4)) uut (
    .CLK_I(clk), .ARST_N_I(arst_n), .RX_DATA_I(rx_data),
    .RX_VALID_I(rx_valid), .RX_READY_O(rdy), .CMD_VALID_O(cv),
    .CMD_INS_O(ins), .CMD_OFFSET_O(off), .CMD_LEN_O(len),
    .CMD_REC_MODE_O(rmode), .CMD_REC_NUM_O(rnum), .CMD_SEEK_DIR_O(sdir),
    .CMD_SEEK_TYPE2_O(st2), .CMD_CODE2_O(c2), .CMD_PEND_INS_O(pend),
    .DATA_O(dat), .DATA_VALID_O(dv), .DATA_READY_I(drdy), .DONE_I(done),
    .DONE_SW1_I(dsw1), .DONE_SW2_I(8'h00), .DONE_OVF_I(ovf),
    .RESP_LEN_I(rlen), .SW_VALID_O(swv), .SW1_O(s1), .SW2_O(s2));
  scd_backend_model bem (
    .clk_i(clk), .arst_n_i(arst_n), .cmd_valid_i(cv), .cmd_ins_i(ins),
    .cmd_len_i(len), .data_i(dat), .data_valid_i(dv), .data_ready_o(drdy),
    .slow_i(slow), .done_o(done), .sw1_o(dsw1), .got_o(got), .last_o(last));
  always @(negedge clk)
  begin
    if (cv === 1'b1) ncmd = ncmd + 1;
    if (arst_n && rdy === 1'b0) saw_full = 1'b1;
  end
  // ==========================================================
  // common tasks
  task give_verdict;
  begin
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end
  endtask
  task chk(input [15:0] g, input [15:0] e);
  begin
    checked = checked + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  end
  endtask
  task hang;
  begin
    errors = errors + 1;
    $display("CHECK FAILED %0t wait ran out", $time);
    give_verdict;
  end
  endtask
  task put(input [7:0] b);
    integer n;
  begin
    rx_data <= b;
    rx_valid <= 1'b1;
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 200)
    begin
      n = n + 1;
      @(negedge clk);
    end
    if (n >= 200) hang;
    @(posedge clk);
  end
  endtask
  task cmd(input [7:0] cl, i, p1, p2, p3, input integer nd);
    integer k;
  begin
    @(posedge clk);
    put(cl); put(i); put(p1); put(p2); put(p3);
    for (k = 0; k < nd; k = k + 1) put(8'h30 + k[7:0]);
    rx_valid <= 1'b0;
    k = 0;
    @(negedge clk);
    while (swv !== 1'b1 && k < 2000)
    begin
      k = k + 1;
      @(negedge clk);
    end
    if (k >= 2000) hang;
    sw_word = {s1, s2};
  end
  endtask
  // ==========================================================
  // scenarios
  task t_first;
  begin
    cmd(8'hA0, 8'hC0, 8'h00, 8'h00, 8'h16, 0);
    chk({8'h00, pend}, 16'h00A4);
    chk(sw_word, 16'h9000);
    cmd(8'hA0, 8'hC0, 8'h00, 8'h00, 8'h16, 0);
    chk(sw_word, 16'h6F00);
    $display("first command test done");
  end
  endtask
  task t_binary;
  begin
    slow = 1'b1;
    cmd(8'hA0, 8'hD6, 8'h12, 8'h34, 8'h03, 3);
    chk(off, 16'h1234);
    chk({8'h00, ins}, 16'h00D6);
    chk({got, len}, 16'h0303);
    chk({8'h00, last}, 16'h0032);
    chk(sw_word, 16'h9000);
    slow = 1'b0;
    $display("binary test done");
  end
  endtask
  task t_record;
    integer i;
    reg [31:0] t1;
    reg [31:0] t2;
    reg [7:0] p1;
  begin
    t1 = 32'h55AA0700;
    t2 = 32'h02030404;
    for (i = 0; i < 4; i = i + 1)
    begin
      p1 = t1[31-8*i -: 8];
      if (i[0]) cmd(8'hA0, 8'hDC, p1, t2[31-8*i -: 8], 8'h01, 1);
      else cmd(8'hA0, 8'hB2, p1, t2[31-8*i -: 8], 8'h04, 0);
      chk({14'h0000, rmode}, i[15:0]);
      chk({8'h00, rnum}, {8'h00, i < 2 ? 8'h00 : p1});
    end
    cmd(8'hA0, 8'hB2, 8'h00, 8'h02, 8'h04, 0);
    chk({rmode, 6'h00, rnum}, 16'h0000);
    cmd(8'hA0, 8'hB2, 8'h01, 8'h05, 8'h04, 0);
    chk(sw_word, 16'h6B00);
    $display("record test done");
  end
  endtask
  task t_seek;
    integer d;
  begin
    cmd(8'hA0, 8'hA2, 8'h00, 8'h13, 8'h02, 2);
    chk({13'h0000, st2, sdir}, 16'h0007);
    chk(sw_word, 16'h9F01);
    cmd(8'hA0, 8'hC0, 8'h00, 8'h00, 8'h01, 0);
    chk({8'h00, pend}, 16'h00A2);
    chk(sw_word, 16'h9000);
    for (d = 0; d < 3; d = d + 1)
    begin
      cmd(8'hA0, 8'hA2, 8'h00, d[7:0], 8'h01, 1);
      chk({13'h0000, st2, sdir}, d[15:0]);
      chk(sw_word, 16'h9000);
    end
    $display("search test done");
  end
  endtask
  task t_increase;
  begin
    ovf = 1'b1;
    cmd(8'hA0, 8'h32, 8'h00, 8'h00, 8'h03, 3);
    chk(sw_word, 16'h9850);
    ovf = 1'b0;
    rlen = 8'h08;
    cmd(8'hA0, 8'h32, 8'h00, 8'h00, 8'h03, 3);
    chk(sw_word, 16'h9F08);
    cmd(8'hA0, 8'h32, 8'h00, 8'h00, 8'h02, 0);
    chk(sw_word, 16'h6700);
    cmd(8'hA0, 8'hC2, 8'h00, 8'h00, 8'h02, 2);
    chk(sw_word, 16'h9F08);
    cmd(8'hA0, 8'hC0, 8'h00, 8'h00, 8'h09, 0);
    chk(sw_word, 16'h6700);
    $display("increase test done");
  end
  endtask
  task t_codes;
  begin
    cmd(8'hA0, 8'h20, 8'h00, 8'h01, 8'h08, 8);
    chk({c2, got, sw_word[15:9]}, {1'b0, 8'h08, 7'h48});
    cmd(8'hA0, 8'h24, 8'h00, 8'h02, 8'h10, 16);
    chk({c2, got, sw_word[15:9]}, {1'b1, 8'h10, 7'h48});
    cmd(8'hA0, 8'h2C, 8'h00, 8'h00, 8'h10, 16);
    chk({c2, sw_word[14:0]}, 16'h1000);
    cmd(8'hA0, 8'h2C, 8'h00, 8'h01, 8'h10, 0);
    chk(sw_word, 16'h6B00);
    cmd(8'hA0, 8'h20, 8'h00, 8'h01, 8'h10, 0);
    chk(sw_word, 16'h6700);
    $display("secret code test done");
  end
  endtask
  task t_auth;
  begin
    slow = 1'b1;
    cmd(8'hA0, 8'h88, 8'h00, 8'h00, 8'h10, 16);
    chk(sw_word, 16'h9F0C);
    chk({7'h00, saw_full, got}, 16'h0110);
    slow = 1'b0;
    $display("authentication test done");
  end
  endtask
  task t_misc;
    integer n0;
  begin
    n0 = ncmd;
    cmd(8'hA0, 8'hFA, 8'h00, 8'h00, 8'h00, 0);
    chk(sw_word, 16'h9000);
    chk(ncmd[15:0], n0[15:0]);
    cmd(8'hA1, 8'hB0, 8'h00, 8'h00, 8'h01, 0);
    chk(sw_word, 16'h6E00);
    cmd(8'hA0, 8'h77, 8'h00, 8'h00, 8'h00, 0);
    chk(sw_word, 16'h6D00);
    // second activation must restore the root selection data
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    cmd(8'hA0, 8'hC0, 8'h00, 8'h00, 8'h16, 0);
    chk({8'h00, pend}, 16'h00A4);
    chk(sw_word, 16'h9000);
    $display("misc test done");
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_first;
    t_binary;
    t_record;
    t_seek;
    t_increase;
    t_codes;
    t_auth;
    t_misc;
    give_verdict;
  end
endmodule // testbench
